/* File: hdl/lmb_regs.svh */
// Register indices, field layout, reset values and sizes of the LAPD buffer port
`ifndef LMB_REGS_SVH
`define LMB_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define LMB_IDX_SELECT    16'h011b
`define LMB_IDX_WINDOW    16'h0700
`define LMB_IDX_STATUS    16'h0120
`define LMB_IDX_INT_STAT  16'h0121
`define LMB_IDX_INT_MASK  16'h0122

// Message store geometry
`define LMB_DEPTH         7'h60
`define LMB_LAST          7'h5f
`define LMB_FIRST         7'h00
`define LMB_NCTRL         3
`define LMB_SEL_MAX       2'h2
`define LMB_MEM_AW        9

// Reset values
`define LMB_SEL_RST       2'h0
`define LMB_MASK_RST      3'h0
`define LMB_BYTE_RST      8'h00

// Status register fields
`define LMB_ST_TXFREE_LSB 0
`define LMB_ST_RXPTR_LSB  4
`define LMB_ST_PTR_LSB    8

// Interrupt status fields: end of receive per controller
`define LMB_IS_EOT_LSB    0

// AXI response codes
`define LMB_RESP_OKAY     2'h0
`define LMB_RESP_SLVERR   2'h2

`endif

/* File: hdl/lmb_pkg.sv */
// Types shared by the LAPD buffer port modules
`default_nettype none

package lmb_pkg;

   // Read channel sequencer, one-hot
   typedef enum logic [3:0]
   {
      LMB_RD_IDLE  = 4'b0001,
      LMB_RD_ISSUE = 4'b0010,
      LMB_RD_WAIT  = 4'b0100,
      LMB_RD_RESP  = 4'b1000
   } lmb_rd_state_type;

   typedef logic [8:0] lmb_mem_addr_type;
   typedef logic [7:0] lmb_byte_type;
   typedef logic [1:0] lmb_sel_type;

endpackage

`default_nettype wire

/* File: hdl/lmb_mem_if.sv */
// Two-port carrier between the buffer port and its message store
`timescale 1ns/10ps
`default_nettype none

interface lmb_mem_if;
   import lmb_pkg::*;

   logic             a_en;
   logic             a_we;
   lmb_mem_addr_type a_addr;
   lmb_byte_type     a_wdata;
   lmb_byte_type     a_rdata;
   logic             b_en;
   logic             b_we;
   lmb_mem_addr_type b_addr;
   lmb_byte_type     b_wdata;
   lmb_byte_type     b_rdata;

   modport mem  (input a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                 output a_rdata, b_rdata);
   modport user (output a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                 input a_rdata, b_rdata);
endinterface

`default_nettype wire

/* File: hdl/lmb_mem.sv */
// Dual-port message store, three controller slices of 96 bytes, registered reads
`timescale 1ns/10ps
`default_nettype none

module lmb_mem
#(
   parameter int WORDS = 288                // Three slices of 96 bytes
)
(
   input  wire logic aclk,                  // System clock
   lmb_mem_if.mem    port                   // Bus side a, link side b
);
   import lmb_pkg::*;

   lmb_byte_type mem [WORDS];

   // Both ports write; port a is last so the bus wins a same-address clash
   always_ff @(posedge aclk)
   begin
      if (port.b_en && port.b_we)
      begin
         mem[port.b_addr] <= port.b_wdata;
      end
      if (port.a_en && port.a_we)
      begin
         mem[port.a_addr] <= port.a_wdata;
      end
   end

   // Read data come out of registers
   always_ff @(posedge aclk)
   begin
      if (port.a_en && !port.a_we)
      begin
         port.a_rdata <= mem[port.a_addr];
      end
      if (port.b_en && !port.b_we)
      begin
         port.b_rdata <= mem[port.b_addr];
      end
   end
endmodule

`default_nettype wire

/* File: hdl/lmb_port.sv */
// LAPD message buffer one: AXI4-Lite window onto the per-controller message store
`timescale 1ns/10ps
`default_nettype none
`include "lmb_regs.svh"

module lmb_port
(
   input  wire logic               aclk,                    // 125 MHz clock
   input  wire logic               aresetn,                 // Sync reset, active low
   input  wire logic [15:0]        s_axi_awaddr,            // Write address
   input  wire logic               s_axi_awvalid,           // Write address valid
   output logic                    s_axi_awready,           // Write address ready
   input  wire logic [31:0]        s_axi_wdata,             // Write data
   input  wire logic [3:0]         s_axi_wstrb,             // Write strobes
   input  wire logic               s_axi_wvalid,            // Write data valid
   output logic                    s_axi_wready,            // Write data ready
   output logic [1:0]              s_axi_bresp,             // Write response
   output logic                    s_axi_bvalid,            // Write response valid
   input  wire logic               s_axi_bready,            // Write response ready
   input  wire logic [15:0]        s_axi_araddr,            // Read address
   input  wire logic               s_axi_arvalid,           // Read address valid
   output logic                    s_axi_arready,           // Read address ready
   output logic [31:0]             s_axi_rdata,             // Read data
   output logic [1:0]              s_axi_rresp,             // Read response
   output logic                    s_axi_rvalid,            // Read data valid
   input  wire logic               s_axi_rready,            // Read data ready
   output logic                    irq,                     // Level interrupt
   input  wire logic [2:0]         tx_buffer_free_flag,     // Buffer one free, per ctrl
   input  wire logic [2:0]         rx_filled_buffer_pointer,// Buffer one filled, per ctrl
   input  wire logic [2:0]         rx_end_of_transfer_event,// Receive done pulse, per ctrl
   input  wire logic [2:0]         tx_message_sent,         // Transmit done pulse, per ctrl
   input  wire logic               link_en,                 // Link store access
   input  wire logic               link_we,                 // Link write, else read
   input  wire lmb_pkg::lmb_sel_type link_ctrl,             // Link controller number
   input  wire logic [6:0]         link_addr,               // Link byte position
   input  wire lmb_pkg::lmb_byte_type link_wdata,           // Received byte to store
   output lmb_pkg::lmb_byte_type   link_rdata,              // Byte to send, one cycle late
   output lmb_pkg::lmb_sel_type    selected_ctrl,           // Current controller select
   output logic [6:0]              tx_byte_count            // Bytes loaded this message
);
   import lmb_pkg::*;

   // Byte address of a register index
   function automatic logic [15:0] lmb_byte_addr(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction

   // Store location of a controller slice and a byte position
   function automatic lmb_mem_addr_type lmb_mem_addr(input lmb_sel_type s,
                                                     input logic [6:0] p);
      return 9'(s) * 9'(`LMB_DEPTH) + 9'(p);
   endfunction

   lmb_mem_if mif ();

   lmb_rd_state_type rd_state_reg;
   logic             aw_hold_reg;
   logic             w_hold_reg;
   logic [15:0]      waddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic [15:0]      raddr_reg;
   lmb_sel_type      sel_reg;
   logic [6:0]       ptr_reg;
   logic [6:0]       ptr_next;
   logic             restart_reg;
   logic             last_rd_reg;
   logic [2:0]       sent_reg;
   logic [2:0]       int_stat_reg;
   logic [2:0]       int_mask_reg;
   logic             wr_do;
   logic             rd_do;
   logic             win_wr;
   logic             win_rd;
   logic             win_fresh;
   logic [6:0]       win_pos;
   logic             sel_wr;
   logic             is_rd_clr;
   logic [2:0]       sent_next;

   // Store instance
   lmb_mem u_mem
   (
      .aclk (aclk),
      .port (mif.mem)
   );

   // Write channel: address and data taken in either order, both held till response
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign wr_do         = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         waddr_reg   <= 16'h0000;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            waddr_reg   <= s_axi_awaddr;
         end
         else if (wr_do)
         begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (wr_do)
         begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LMB_RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         case (waddr_reg)
            lmb_byte_addr(`LMB_IDX_SELECT),
            lmb_byte_addr(`LMB_IDX_WINDOW),
            lmb_byte_addr(`LMB_IDX_STATUS),
            lmb_byte_addr(`LMB_IDX_INT_STAT),
            lmb_byte_addr(`LMB_IDX_INT_MASK): s_axi_bresp <= `LMB_RESP_OKAY;
            default:                          s_axi_bresp <= `LMB_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Decoded write effects
   assign sel_wr = wr_do && wstrb_reg[0] && waddr_reg == lmb_byte_addr(`LMB_IDX_SELECT);
   assign win_wr = wr_do && wstrb_reg[0] && waddr_reg == lmb_byte_addr(`LMB_IDX_WINDOW)
                   && tx_buffer_free_flag[sel_reg];

   // Read channel: a read waits a cycle while any write completes, whatever its address
   assign s_axi_arready = rd_state_reg == LMB_RD_IDLE;
   assign rd_do         = rd_state_reg == LMB_RD_ISSUE && !wr_do;
   assign win_rd        = rd_do && raddr_reg == lmb_byte_addr(`LMB_IDX_WINDOW);
   assign is_rd_clr     = rd_do && raddr_reg == lmb_byte_addr(`LMB_IDX_INT_STAT);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_reg <= LMB_RD_IDLE;
         raddr_reg    <= 16'h0000;
      end
      else
      begin
         unique case (rd_state_reg)
            LMB_RD_IDLE:
            begin
               if (s_axi_arvalid)
               begin
                  raddr_reg    <= s_axi_araddr;
                  rd_state_reg <= LMB_RD_ISSUE;
               end
            end
            LMB_RD_ISSUE:
            begin
               if (win_rd)
               begin
                  rd_state_reg <= LMB_RD_WAIT;
               end
               else if (rd_do)
               begin
                  rd_state_reg <= LMB_RD_RESP;
               end
            end
            LMB_RD_WAIT: rd_state_reg <= LMB_RD_RESP;
            LMB_RD_RESP:
            begin
               if (s_axi_rready)
               begin
                  rd_state_reg <= LMB_RD_IDLE;
               end
            end
         endcase
      end
   end

   // Read data and response, registered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `LMB_RESP_OKAY;
      end
      else if (rd_do)
      begin
         s_axi_rresp <= `LMB_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         case (raddr_reg)
            lmb_byte_addr(`LMB_IDX_SELECT):   s_axi_rdata[1:0] <= sel_reg;
            lmb_byte_addr(`LMB_IDX_WINDOW):   s_axi_rdata      <= 32'h0000_0000;
            lmb_byte_addr(`LMB_IDX_STATUS):
            begin
               s_axi_rdata[`LMB_ST_TXFREE_LSB +: 3] <= tx_buffer_free_flag;
               s_axi_rdata[`LMB_ST_RXPTR_LSB +: 3]  <= rx_filled_buffer_pointer;
               s_axi_rdata[`LMB_ST_PTR_LSB +: 7]    <= ptr_reg;
            end
            lmb_byte_addr(`LMB_IDX_INT_STAT): s_axi_rdata[2:0] <= int_stat_reg;
            lmb_byte_addr(`LMB_IDX_INT_MASK): s_axi_rdata[2:0] <= int_mask_reg;
            default:                          s_axi_rresp      <= `LMB_RESP_SLVERR;
         endcase
      end
      else if (rd_state_reg == LMB_RD_WAIT)
      begin
         s_axi_rdata[7:0] <= sent_reg[sel_reg] ? `LMB_BYTE_RST : mif.a_rdata;
      end
   end
   assign s_axi_rvalid = rd_state_reg == LMB_RD_RESP;

   // Controller select; codes above the last controller are ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel_reg <= `LMB_SEL_RST;
      end
      else if (sel_wr && wdata_reg[1:0] <= `LMB_SEL_MAX)
      begin
         sel_reg <= wdata_reg[1:0];
      end
   end
   assign selected_ctrl = sel_reg;

   // A fresh message starts at the first byte; direction change also restarts
   assign win_fresh = restart_reg || (win_wr && last_rd_reg) || (win_rd && !last_rd_reg);
   assign win_pos   = win_fresh ? `LMB_FIRST : ptr_reg;

   always_comb
   begin
      ptr_next = (win_pos == `LMB_LAST) ? `LMB_LAST : win_pos + 7'h01;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ptr_reg       <= `LMB_FIRST;
         last_rd_reg   <= 1'b0;
         tx_byte_count <= 7'h00;
      end
      else if (win_wr || win_rd)
      begin
         ptr_reg     <= ptr_next;
         last_rd_reg <= win_rd;
         if (win_wr)
         begin
            tx_byte_count <= (win_pos == `LMB_LAST) ? `LMB_DEPTH : ptr_next;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         restart_reg <= 1'b1;
      end
      else if (sel_wr || rx_end_of_transfer_event[sel_reg] || tx_message_sent[sel_reg])
      begin
         restart_reg <= 1'b1;
      end
      else if (win_wr || win_rd)
      begin
         restart_reg <= 1'b0;
      end
   end

   // Sent marks: set by the link, cleared by a new load or a new reception
   always_comb
   begin
      sent_next = sent_reg;
      for (int i = 0; i < `LMB_NCTRL; i++)
      begin
         if (rx_end_of_transfer_event[i] || (win_wr && sel_reg == 2'(i)))
         begin
            sent_next[i] = 1'b0;
         end
         if (tx_message_sent[i])
         begin
            sent_next[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sent_reg <= 3'h0;
      end
      else
      begin
         sent_reg <= sent_next;
      end
   end

   // Interrupt status: end of receive sticky, read clears, a new event wins the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_stat_reg <= 3'h0;
      end
      else
      begin
         int_stat_reg <= (is_rd_clr ? 3'h0 : int_stat_reg) |
                         (rx_end_of_transfer_event << `LMB_IS_EOT_LSB);
      end
   end

   // Interrupt mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         int_mask_reg <= `LMB_MASK_RST;
      end
      else if (wr_do && wstrb_reg[0] && waddr_reg == lmb_byte_addr(`LMB_IDX_INT_MASK))
      begin
         int_mask_reg <= wdata_reg[2:0];
      end
   end
   assign irq = |(int_stat_reg & int_mask_reg);

   assign mif.a_en    = win_wr || win_rd;
   assign mif.a_we    = win_wr;
   assign mif.a_addr  = lmb_mem_addr(sel_reg, win_pos);
   assign mif.a_wdata = wdata_reg[7:0];

   // Store port b, link side
   assign mif.b_en    = link_en;
   assign mif.b_we    = link_we;
   assign mif.b_addr  = lmb_mem_addr(link_ctrl, link_addr);
   assign mif.b_wdata = link_wdata;
   assign link_rdata  = mif.b_rdata;
endmodule

`default_nettype wire

/* File: verif/lmb_port_chk.sv */
// Concurrent checks on the ports of the LAPD buffer port
`timescale 1ns/10ps
`default_nettype none

module lmb_chk
(
   input wire logic        aclk,          // Clock
   input wire logic        aresetn,       // Sync reset, active low
   input wire logic        s_axi_awvalid, // Aw valid
   input wire logic        s_axi_awready, // Aw ready
   input wire logic        s_axi_wvalid,  // W valid
   input wire logic        s_axi_wready,  // W ready
   input wire logic        s_axi_bvalid,  // B valid
   input wire logic        s_axi_arvalid, // Ar valid
   input wire logic        s_axi_arready, // Ar ready
   input wire logic [31:0] s_axi_rdata,   // Read data
   input wire logic [1:0]  s_axi_rresp,   // Read response
   input wire logic        s_axi_rvalid,  // R valid
   input wire logic        irq,           // Interrupt
   input wire logic [1:0]  selected_ctrl, // Controller select
   input wire logic [6:0]  tx_byte_count  // Loaded bytes
);
   // All checks share one clock and reset
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   reset_values_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
      && selected_ctrl == 2'h0 && tx_byte_count == 7'h00) else $error("bad state after reset");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:4] s_axi_rvalid)
      else $error("read answer late");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   sel_range_a: assert property (selected_ctrl != 2'h3) else $error("select out of range");
   cnt_max_a: assert property (tx_byte_count <= 7'h60) else $error("count past 96");
   cnt_step_a: assert property (tx_byte_count > $past(tx_byte_count)
      |-> tx_byte_count == $past(tx_byte_count) + 7'h01) else $error("count jumped");
endmodule

bind lmb_port lmb_chk chk_i
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .irq(irq), .selected_ctrl(selected_ctrl), .tx_byte_count(tx_byte_count)
);

`default_nettype wire

/* File: verif/lmb_port_test.sv */
// Bus-level self-checking bench for the LAPD buffer port
`timescale 1ns/10ps
`default_nettype none

module lmb_port_test;
   import lmb_pkg::*;

   localparam logic [15:0] A_SEL = 16'h046c;
   localparam logic [15:0] A_WIN = 16'h1c00;
   localparam logic [15:0] A_ST  = 16'h0480;
   localparam logic [15:0] A_IS  = 16'h0484;
   localparam logic [15:0] A_IM  = 16'h0488;

   logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic         awready, wready, bvalid, arready, rvalid, irq, link_en, link_we;
   logic [15:0]  awaddr, araddr;
   logic [31:0]  wdata, rdata, d;
   logic [1:0]   bresp, rresp, b_r, r_r;
   logic [3:0]   strb;
   logic [2:0]   tx_free, rx_ptr, eot, sent;
   lmb_sel_type  link_ctrl, sel;
   logic [6:0]   link_addr, cnt;
   lmb_byte_type link_wdata, link_rdata;
   int           fail_count, n_checks, i, c;

   lmb_port uut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq), .tx_buffer_free_flag(tx_free), .rx_filled_buffer_pointer(rx_ptr),
      .rx_end_of_transfer_event(eot), .tx_message_sent(sent), .link_en(link_en),
      .link_we(link_we), .link_ctrl(link_ctrl), .link_addr(link_addr), .link_wdata(link_wdata),
      .link_rdata(link_rdata), .selected_ctrl(sel), .tx_byte_count(cnt)
   );

   // Free-running 125 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   task automatic conclude();
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Handshakes sampled at the falling edge, which matches the next rising edge
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      int   n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 50 && !tb; n++)
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         b_r = bresp;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!tb)
      begin
         fail_count++;
         conclude();
      end
   endtask

   task automatic rd(input logic [15:0] a);
      logic ta, tr;
      int   n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 50 && !tr; n++)
      begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r_r = rresp;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!tr)
      begin
         fail_count++;
         conclude();
      end
   endtask

   // One link-side store access
   task automatic lk(input logic we, input lmb_sel_type k, input logic [6:0] a,
                     input lmb_byte_type v);
      @(posedge aclk);
      link_en <= 1'b1;
      link_we <= we;
      link_ctrl <= k;
      link_addr <= a;
      link_wdata <= v;
      @(posedge aclk);
      link_en <= 1'b0;
   endtask

   // One-cycle receive-done and sent pulses
   task automatic ev(input logic [2:0] e, input logic [2:0] s);
      @(posedge aclk);
      eot <= e;
      sent <= s;
      @(posedge aclk);
      eot <= 3'h0;
      sent <= 3'h0;
   endtask

   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, link_en, link_we} = 8'h00;
      {awaddr, araddr, wdata, link_ctrl, link_addr, link_wdata} = 81'h0;
      {tx_free, rx_ptr, eot, sent} = 12'h000;
      strb = 4'hf;
      fail_count = 0;
      n_checks = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_SEL);
      chk(d, 32'h0);
      chk({30'h0, sel}, 32'h0);
      rd(A_IM);
      chk(d, 32'h0);
      rd(A_ST);
      chk(d, 32'h0);
      wr(16'h0010, 32'h1);
      chk({30'h0, b_r}, 32'h2);
      rd(16'h0010);
      chk({r_r, d[29:0]}, 32'h80000000);
      tx_free <= 3'h5;
      rx_ptr <= 3'h2;
      rd(A_ST);
      chk(d, 32'h25);
      tx_free <= 3'h7;
      // separate slices per controller, bad select ignored
      for (c = 0; c < 3; c++)
      begin
         wr(A_SEL, 32'(c));
         wr(A_SEL, 32'h3);
         rd(A_SEL);
         chk(d, 32'(c));
         chk({30'h0, sel}, 32'(c));
         for (i = 0; i < 4; i++)
            wr(A_WIN, 32'(c * 16 + i));
         chk({25'h0, cnt}, 32'h4);
      end
      for (c = 0; c < 3; c++)
      begin
         wr(A_SEL, 32'(c));
         for (i = 0; i < 4; i++)
         begin
            rd(A_WIN);
            chk(d, 32'(c * 16 + i));
         end
      end
      // no load while busy, gone once sent
      wr(A_SEL, 32'h0);
      tx_free <= 3'h6;
      wr(A_WIN, 32'haa);
      tx_free <= 3'h7;
      wr(A_SEL, 32'h0);
      rd(A_WIN);
      chk(d, 32'h0);
      wr(A_SEL, 32'h1);
      ev(3'h0, 3'h2);
      rd(A_WIN);
      chk(d, 32'h0);
      // whole message; writes past the end land on the last place
      for (i = 0; i < 98; i++)
         wr(A_WIN, 32'(i));
      chk({25'h0, cnt}, 32'h60);
      for (i = 0; i < 97; i++)
      begin
         rd(A_WIN);
         chk(d, 32'(i < 95 ? i : 97));
      end
      lk(1'b0, 2'h1, 7'h05, 8'h00);
      @(negedge aclk);
      chk({24'h0, link_rdata}, 32'h5);
      // received message, interrupt enabled by the mask, set, cleared by a read
      wr(A_IM, 32'h4);
      for (i = 0; i < 3; i++)
         lk(1'b1, 2'h2, 7'(i), 8'(8'hc0 + i));
      ev(3'h4, 3'h0);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      rd(A_IS);
      chk(d, 32'h4);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(A_IS);
      chk(d, 32'h0);
      wr(A_SEL, 32'h2);
      for (i = 0; i < 3; i++)
      begin
         rd(A_WIN);
         chk(d, 32'(8'hc0 + i));
      end
      // end of receive on the selected controller restarts readout
      ev(3'h4, 3'h0);
      rd(A_WIN);
      chk(d, 32'hc0);
      wr(A_IM, 32'h0);
      ev(3'h1, 3'h0);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(A_IS);
      chk(d, 32'h5);
      // only byte lane 0 carries register data
      strb <= 4'he;
      wr(A_IM, 32'h7);
      strb <= 4'hf;
      rd(A_IM);
      chk(d, 32'h0);
      conclude();
   end
endmodule

`default_nettype wire
